// file: hw/sdh_cmd_path.sv
// sd host clock generator and command path with ahb-lite registers
// How it works
// - card clock is an output; cmd bits change on falling, sampled on rising edge
// - one clock, one cmd, four data lines; single-line mode shows only data line zero
// - for divider one and up, card clock rate equals hclk divided by divider field plus one
// - halt bit zero keeps card clock running, one stops it
// - every command leaves as one 48-bit serial packet
// - packet carries a 6-bit command number and 32-bit argument
// - start 0, transmission 1, argument bits 39..8, crc7 bits 7..1, end 1
// - command number from index field, argument from argument register
// - expect and long bits choose none, 48-bit or 136-bit response
// - complete flag on sent no-response command or any timely response
// - 48-bit response crc mismatch sets the crc error flag; 136-bit responses are not checked
// - no response start bit within timeout sets the timeout flag
// - busy bit shows a running command; launches meanwhile are ignored
// - data status register shows card busy on data line zero
// - response index and arguments stored; short argument in first word
`timescale 1ns/1ps
module sdh_cmd_path (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             card_clk,
  output logic             cmd_o,
  output logic             cmd_oe,
  input  wire logic        cmd_i,
  input  wire logic [3:0]  dat_i,
  output logic             irq
);
  import sdh_pkg::*;

  // configuration and status registers
  logic [7:0]  div_q;
  logic        halt_q;
  logic        wide_q;
  logic [5:0]  idx_q;
  logic        rexp_q;
  logic        long_q;
  logic        txen_q;
  logic [31:0] arg_q;
  logic [31:0] tmo_q;
  logic        done_q;
  logic        crcerr_q;
  logic        tmoflag_q;
  logic [2:0]  ien_q;
  logic [5:0]  ridx_q;
  logic [31:0] rarg_q [4];

  // bus pipeline
  logic        wr_pend_q;
  logic [7:0]  waddr_q;
  logic [31:0] rdata_d;

  // link side
  logic [7:0]   cnt_q;
  logic [7:0]   cnt_d;
  logic         clk_d;
  sdh_state_t   state_q;
  logic [5:0]   bitcnt_q;
  logic [39:0]  tx_sh_q;
  logic [7:0]   rxcnt_q;
  logic [135:0] rx_sh_q;
  logic [31:0]  tcnt_q;
  logic         cmd_s;
  logic [3:0]   dat_s;
  logic [6:0]   crc_tx;
  logic [6:0]   crc_rx;

  // address phase decode
  wire         addr_take = hsel & htrans[1] & hready;
  wire         wr_take   = addr_take & hwrite;
  wire         rd_take   = addr_take & ~hwrite;
  wire [7:0]   raddr     = haddr[7:0];

  // data phase write strobes
  wire         we_clk  = wr_pend_q & (waddr_q == OFF_CLK_CTRL);
  wire         we_cmd  = wr_pend_q & (waddr_q == OFF_CMD_CTRL);
  wire         we_arg  = wr_pend_q & (waddr_q == OFF_CMD_ARG);
  wire         we_tmo  = wr_pend_q & (waddr_q == OFF_TIMEOUT);
  wire         we_sts  = wr_pend_q & (waddr_q == OFF_STATUS);
  wire         we_ien  = wr_pend_q & (waddr_q == OFF_IRQ_EN);

  // command engine control
  wire         busy      = (state_q != ST_IDLE);
  wire         launch    = we_cmd & hwdata[B_LAUNCH] & hwdata[B_TX_EN] & ~busy;

  // card clock divider
  wire [8:0]   period    = {1'b0, div_q} + 9'd1;
  wire [7:0]   half      = period[8:1];
  wire [7:0]   half_m1   = half - 8'd1;
  wire         wrap      = (cnt_q >= div_q);
  wire         rise_evt  = ~halt_q & wrap;
  wire         fall_evt  = ~halt_q & (cnt_q == half_m1);

  // transmit bit selection
  wire [5:0]   crc_pos   = TX_CRC_TOP - bitcnt_q;
  wire [2:0]   crc_sel   = crc_pos[2:0];
  wire         in_data   = (bitcnt_q < TX_DATA_BITS);
  wire         tx_bit    = in_data ? tx_sh_q[39] :
                           (bitcnt_q < TX_END_BIT) ? crc_tx[crc_sel] : 1'b1;
  wire         tx_crc_en = (state_q == ST_SEND) & fall_evt & in_data;

  // receive control
  wire         start_seen = (state_q == ST_WAIT) & rise_evt & ~cmd_s;
  wire         rx_bit_evt = (state_q == ST_RECV) & rise_evt;
  wire         rx_crc_en  = start_seen | (rx_bit_evt & (rxcnt_q < RX_CRC_BITS));
  wire [7:0]   rx_last    = long_q ? RX_LAST_LONG : RX_LAST_SHORT;
  wire         rx_crc_bad = ~long_q & (rx_sh_q[7:1] != crc_rx);
  wire         tmo_hit    = (state_q == ST_WAIT) & rise_evt & cmd_s & (tcnt_q == tmo_q);

  // flag set events
  wire         set_done  = ((state_q == ST_SEND) & fall_evt & (bitcnt_q == TX_BITS) & ~rexp_q)
                           | (state_q == ST_CHECK);
  wire         set_crc   = (state_q == ST_CHECK) & rx_crc_bad;
  wire         set_tmo   = tmo_hit;
  wire         clr_done  = we_sts & hwdata[B_ST_DONE];
  wire         clr_crc   = we_sts & hwdata[B_ST_CRC];
  wire         clr_tmo   = we_sts & hwdata[B_ST_TMO];

  // data line status: busy is data line zero held low
  wire [3:0]   dat_view  = wide_q ? dat_s : {3'b000, dat_s[0]};
  wire [31:0]  dat_stat  = {24'h0, dat_view, 3'b000, ~dat_s[0]};

  wire [31:0]  status    = {28'h0, busy, tmoflag_q, crcerr_q, done_q};

  sdh_sync #(.W(1)) u_sync_cmd (
    .clk   (hclk),
    .rst_n (hresetn),
    .din   (cmd_i),
    .dout  (cmd_s)
  );

  sdh_sync #(.W(4)) u_sync_dat (
    .clk   (hclk),
    .rst_n (hresetn),
    .din   (dat_i),
    .dout  (dat_s)
  );

  sdh_crc7 u_crc_tx (
    .clk   (hclk),
    .rst_n (hresetn),
    .clr   (launch),
    .en    (tx_crc_en),
    .din   (tx_sh_q[39]),
    .crc   (crc_tx)
  );

  sdh_crc7 u_crc_rx (
    .clk   (hclk),
    .rst_n (hresetn),
    .clr   (launch),
    .en    (rx_crc_en),
    .din   (cmd_s),
    .crc   (crc_rx)
  );

  // read mux on the address phase, registered into the data phase
  always_comb begin
    case (raddr)
      OFF_CLK_CTRL:  rdata_d = {22'h0, wide_q, halt_q, div_q};
      OFF_CMD_CTRL:  rdata_d = {21'h0, txen_q, long_q, rexp_q, 2'b00, idx_q};
      OFF_CMD_ARG:   rdata_d = arg_q;
      OFF_TIMEOUT:   rdata_d = tmo_q;
      OFF_STATUS:    rdata_d = status;
      OFF_IRQ_EN:    rdata_d = {29'h0, ien_q};
      OFF_RESP_IDX:  rdata_d = {26'h0, ridx_q};
      OFF_RESP_ARG0: rdata_d = rarg_q[0];
      OFF_RESP_ARG1: rdata_d = rarg_q[1];
      OFF_RESP_ARG2: rdata_d = rarg_q[2];
      OFF_RESP_ARG3: rdata_d = rarg_q[3];
      OFF_DAT_STAT:  rdata_d = dat_stat;
      default:       rdata_d = 32'h0;
    endcase
  end

  // bus slave: zero wait states, always okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      waddr_q   <= 8'h00;
      hrdata    <= 32'h0;
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      wr_pend_q <= wr_take;
      waddr_q   <= raddr;
      hrdata    <= rd_take ? rdata_d : 32'h0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // software written configuration
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_q  <= RST_DIV;
      halt_q <= RST_HALT;
      wide_q <= 1'b0;
      idx_q  <= 6'h00;
      rexp_q <= 1'b0;
      long_q <= 1'b0;
      txen_q <= 1'b0;
      arg_q  <= 32'h0;
      tmo_q  <= RST_TIMEOUT;
      ien_q  <= 3'b000;
    end else begin
      if (we_clk) begin
        div_q  <= hwdata[7:0];
        halt_q <= hwdata[B_CLK_HALT];
        wide_q <= hwdata[B_CLK_WIDE];
      end
      // command settings and argument are frozen while a command runs
      if (we_cmd & ~busy) begin
        idx_q  <= hwdata[5:0];
        rexp_q <= hwdata[B_RESP_EXP];
        long_q <= hwdata[B_RESP_LONG];
        txen_q <= hwdata[B_TX_EN];
      end
      if (we_arg & ~busy) begin
        arg_q <= hwdata;
      end
      if (we_tmo) begin
        tmo_q <= hwdata;
      end
      if (we_ien) begin
        ien_q <= hwdata[2:0];
      end
    end
  end

  // sticky flags, a set in the clearing cycle wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      done_q    <= 1'b0;
      crcerr_q  <= 1'b0;
      tmoflag_q <= 1'b0;
      irq       <= 1'b0;
    end else begin
      done_q    <= set_done | (done_q & ~clr_done);
      crcerr_q  <= set_crc | (crcerr_q & ~clr_crc);
      tmoflag_q <= set_tmo | (tmoflag_q & ~clr_tmo);
      irq       <= |({tmoflag_q, crcerr_q, done_q} & ien_q);
    end
  end

  // card clock: high for the first half of each divided period
  assign cnt_d = halt_q ? 8'h00 : (wrap ? 8'h00 : cnt_q + 8'd1);
  assign clk_d = ~halt_q & (cnt_d < half);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q    <= 8'h00;
      card_clk <= 1'b0;
    end else begin
      cnt_q    <= cnt_d;
      card_clk <= clk_d;
    end
  end

  // command sequencer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q  <= ST_IDLE;
      bitcnt_q <= 6'h00;
      tx_sh_q  <= 40'h0;
      rxcnt_q  <= 8'h00;
      rx_sh_q  <= 136'h0;
      tcnt_q   <= 32'h0;
      cmd_o    <= 1'b1;
      cmd_oe   <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (launch) begin
            state_q  <= ST_SEND;
            bitcnt_q <= 6'h00;
            tx_sh_q  <= {2'b01, hwdata[5:0], arg_q};
          end
        end
        ST_SEND: begin
          if (fall_evt) begin
            if (bitcnt_q == TX_BITS) begin
              cmd_oe <= 1'b0;
              cmd_o  <= 1'b1;
              tcnt_q <= 32'h0;
              state_q <= rexp_q ? ST_WAIT : ST_IDLE;
            end else begin
              cmd_o    <= tx_bit;
              cmd_oe   <= 1'b1;
              bitcnt_q <= bitcnt_q + 6'd1;
              if (in_data) begin
                tx_sh_q <= {tx_sh_q[38:0], 1'b0};
              end
            end
          end
        end
        ST_WAIT: begin
          if (start_seen) begin
            rx_sh_q <= {rx_sh_q[134:0], 1'b0};
            rxcnt_q <= 8'd1;
            state_q <= ST_RECV;
          end else if (tmo_hit) begin
            state_q <= ST_IDLE;
          end else if (rise_evt) begin
            tcnt_q <= tcnt_q + 32'd1;
          end
        end
        ST_RECV: begin
          if (rx_bit_evt) begin
            rx_sh_q <= {rx_sh_q[134:0], cmd_s};
            rxcnt_q <= rxcnt_q + 8'd1;
            if (rxcnt_q == rx_last) begin
              state_q <= ST_CHECK;
            end
          end
        end
        ST_CHECK: begin
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // response capture on completion
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ridx_q    <= 6'h00;
      rarg_q[0] <= 32'h0;
      rarg_q[1] <= 32'h0;
      rarg_q[2] <= 32'h0;
      rarg_q[3] <= 32'h0;
    end else if (state_q == ST_CHECK) begin
      if (long_q) begin
        ridx_q    <= rx_sh_q[133:128];
        rarg_q[0] <= rx_sh_q[127:96];
        rarg_q[1] <= rx_sh_q[95:64];
        rarg_q[2] <= rx_sh_q[63:32];
        rarg_q[3] <= rx_sh_q[31:0];
      end else begin
        ridx_q    <= rx_sh_q[45:40];
        rarg_q[0] <= rx_sh_q[39:8];
      end
    end
  end
endmodule

// file: hw/sdh_pkg.sv
// shared constants and types of the sd host command path
package sdh_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CLK_CTRL  = 8'h00;
  localparam logic [7:0] OFF_CMD_CTRL  = 8'h04;
  localparam logic [7:0] OFF_CMD_ARG   = 8'h08;
  localparam logic [7:0] OFF_TIMEOUT   = 8'h0c;
  localparam logic [7:0] OFF_STATUS    = 8'h10;
  localparam logic [7:0] OFF_IRQ_EN    = 8'h14;
  localparam logic [7:0] OFF_RESP_IDX  = 8'h18;
  localparam logic [7:0] OFF_RESP_ARG0 = 8'h1c;
  localparam logic [7:0] OFF_RESP_ARG1 = 8'h20;
  localparam logic [7:0] OFF_RESP_ARG2 = 8'h24;
  localparam logic [7:0] OFF_RESP_ARG3 = 8'h28;
  localparam logic [7:0] OFF_DAT_STAT  = 8'h2c;

  // field positions
  localparam int B_CLK_HALT  = 8;
  localparam int B_CLK_WIDE  = 9;
  localparam int B_RESP_EXP  = 8;
  localparam int B_RESP_LONG = 9;
  localparam int B_TX_EN     = 10;
  localparam int B_LAUNCH    = 16;
  localparam int B_ST_DONE   = 0;
  localparam int B_ST_CRC    = 1;
  localparam int B_ST_TMO    = 2;
  localparam int B_ST_BUSY   = 3;

  // reset values
  localparam logic [7:0]  RST_DIV     = 8'h77;
  localparam logic        RST_HALT    = 1'b1;
  localparam logic [31:0] RST_TIMEOUT = 32'h0000_00ff;

  // packet bit counts
  localparam logic [5:0] TX_DATA_BITS = 6'd40;
  localparam logic [5:0] TX_END_BIT   = 6'd47;
  localparam logic [5:0] TX_BITS      = 6'd48;
  localparam logic [5:0] TX_CRC_TOP   = 6'd46;
  localparam logic [7:0] RX_CRC_BITS  = 8'd40;
  localparam logic [7:0] RX_LAST_SHORT = 8'd47;
  localparam logic [7:0] RX_LAST_LONG  = 8'd135;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_SEND  = 3'b001,
    ST_WAIT  = 3'b010,
    ST_RECV  = 3'b011,
    ST_CHECK = 3'b100
  } sdh_state_t;
endpackage

// file: hw/sdh_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module sdh_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '1;
      dout   <= '1;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule

// file: hw/sdh_crc7.sv
// serial crc7 engine, polynomial x^7 + x^3 + 1
`timescale 1ns/1ps
module sdh_crc7 (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       clr,
  input  wire logic       en,
  input  wire logic       din,
  output logic      [6:0] crc
);
  logic fb;

  assign fb = din ^ crc[6];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      crc <= 7'h00;
    end else if (clr) begin
      crc <= 7'h00;
    end else if (en) begin
      crc <= {crc[5:3], crc[2] ^ fb, crc[1:0], fb};
    end
  end
endmodule

// file: tb/sdh_cmd_path_assertions.sv
// port-level assertions of the sd host command path
`timescale 1ns/1ps
module sdh_cmd_path_assertions (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic card_clk,
  input wire logic cmd_o,
  input wire logic cmd_oe
);
  logic       card_q;
  logic       card_rise;
  logic [5:0] cnt_q;
  logic [5:0] cnt_d;
  assign card_rise = card_clk && !card_q;
  assign cnt_d     = !cmd_oe ? 6'h00 : cnt_q + 6'(card_rise);
  // counts card clock rises while the host drives the command line
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      card_q <= 1'b0;
      cnt_q  <= 6'h00;
    end else begin
      card_q <= card_clk;
      cnt_q  <= cnt_d;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_launch;
    $rose(cmd_oe) ##0 !cmd_o;
  endsequence
  property p_start_bit; card_rise && cmd_oe && cnt_q == 6'd0 |-> !cmd_o; endproperty
  a_start_bit: assert property (p_start_bit) else $error("start bit not low");
  property p_tx_bit; card_rise && cmd_oe && cnt_q == 6'd1 |-> cmd_o; endproperty
  a_tx_bit: assert property (p_tx_bit) else $error("transmission bit not high");
  property p_end_bit; card_rise && cmd_oe && cnt_q == 6'd47 |-> cmd_o; endproperty
  a_end_bit: assert property (p_end_bit) else $error("end bit not high");
  property p_len; $fell(cmd_oe) |-> cnt_q == 6'd48; endproperty
  a_len: assert property (p_len) else $error("packet length wrong");
  property p_stable; card_rise |-> $stable(cmd_o) && $stable(cmd_oe); endproperty
  a_stable: assert property (p_stable) else $error("cmd moved at card rise");
  property p_oe_hold; s_launch |=> cmd_oe [*8]; endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("packet cut short");
  property p_idle_high; !cmd_oe |-> cmd_o; endproperty
  a_idle_high: assert property (p_idle_high) else $error("cmd low while released");
  property p_okay; hresp == 1'b0; endproperty
  a_okay: assert property (p_okay) else $error("bus response not okay");
  property p_ready; $past(hresetn) |-> hreadyout; endproperty
  a_ready: assert property (p_ready) else $error("wait state inserted");
endmodule
bind sdh_cmd_path sdh_cmd_path_assertions i_chk (
  .hclk, .hresetn, .hreadyout, .hresp, .card_clk, .cmd_o, .cmd_oe);

// file: tb/sdh_card_model.sv
// behavioural card answering commands on the cmd line
`timescale 1ns/1ps
module sdh_card_model (
  input  wire logic        card_clk,
  input  wire logic        cmd_o,
  input  wire logic        cmd_oe,
  input  wire logic [1:0]  mode,
  input  wire logic        bad,
  input  wire logic        busy,
  output logic             cmd_i,
  output logic      [3:0]  dat_i,
  output logic      [47:0] pkt,
  output logic             crc_ok
);
  logic [135:0] r;
  function automatic logic [6:0] crc7(input logic [39:0] v);
    logic [6:0] c;
    c = 7'h00;
    for (int i = 39; i >= 0; i--)
      c = {c[5:0], 1'b0} ^ ((v[i] ^ c[6]) ? 7'h09 : 7'h00);
    return c;
  endfunction
  // pulled-up data lines, line zero held low while busy
  assign dat_i = {3'b111, !busy};
  initial begin
    cmd_i  = 1'b1;
    pkt    = 48'h0;
    crc_ok = 1'b0;
    forever begin
      @(posedge card_clk);
      if (cmd_oe && !cmd_o) begin
        for (int i = 46; i >= 0; i--) begin
          @(posedge card_clk);
          pkt[i] = cmd_o;
        end
        pkt[47] = 1'b0;
        crc_ok  = crc7(pkt[47:8]) === pkt[7:1];
        if (mode != 2'd0) begin
          if (mode == 2'd1)
            r = {2'b00, pkt[45:40], ~pkt[39:8], 8'h01, 88'h0};
          else
            r = {2'b00, 6'h3f, {4{pkt[39:8]}}};
          if (mode == 2'd1)
            r[95:89] = crc7(r[135:96]) ^ {6'h0, bad};
          repeat (2) @(posedge card_clk);
          for (int i = 0; i < ((mode == 2'd1) ? 48 : 136); i++) begin
            @(negedge card_clk);
            cmd_i <= r[135-i];
          end
          @(negedge card_clk);
          cmd_i <= 1'b1;
        end
      end
    end
  end
endmodule

// file: tb/sdh_cmd_path_tb.sv
// self-checking bench of the sd host command path
`timescale 1ns/1ps
module sdh_cmd_path_tb;
  import sdh_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic        card_clk, cmd_o, cmd_oe, cmd_i, irq, bad, busy, crc_ok;
  logic [1:0]  htrans, mode;
  logic [2:0]  ien;
  logic [3:0]  dat_i;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [47:0] pkt;
  int          bad_count, n_tests;
  assign hready = hreadyout;
  sdh_cmd_path i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .card_clk(card_clk),
    .cmd_o(cmd_o), .cmd_oe(cmd_oe), .cmd_i(cmd_i), .dat_i(dat_i), .irq(irq));
  sdh_card_model i_card (.card_clk(card_clk), .cmd_o(cmd_o), .cmd_oe(cmd_oe), .mode(mode),
    .bad(bad), .busy(busy), .cmd_i(cmd_i), .dat_i(dat_i), .pkt(pkt), .crc_ok(crc_ok));
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  task automatic close_out();
    if (bad_count == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  // counts card clock rises seen over c hclk cycles after settling
  task automatic rises(input int c, input int exp);
    int   k;
    logic p;
    k = 0;
    repeat (8) @(posedge hclk);
    p = card_clk;
    repeat (c) begin
      @(posedge hclk);
      if (card_clk && !p) k++;
      p = card_clk;
    end
    chk(32'(k), 32'(exp));
  endtask
  task automatic fresh();
    hresetn <= 1'b0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    ien = 3'h0;
    rdc(OFF_CLK_CTRL, 32'h0000_0177);
    rdc(OFF_TIMEOUT, 32'h0000_00ff);
    rdc(OFF_STATUS, 32'h0);
    rises(40, 0);
    wr(OFF_TIMEOUT, 32'h8);
    wr(OFF_CLK_CTRL, 32'h3);
  endtask
  task automatic cmd(input logic [5:0] idx, input logic [31:0] arg,
                     input logic [1:0] rt, input logic [31:0] st);
    wr(OFF_CMD_ARG, arg);
    wr(OFF_CMD_CTRL, {21'h0, 1'b1, rt, 2'b00, idx});
    rdc(OFF_CMD_CTRL, {21'h0, 1'b1, rt, 2'b00, idx});
    wr(OFF_CMD_CTRL, {15'h0, 1'b1, 5'h0, 1'b1, rt, 2'b00, idx});
    wr(OFF_CMD_CTRL, 32'h0001_043f);
    bus(1'b0, OFF_STATUS, 32'h0);
    chk(rd & 32'h8, 32'h8);
    do bus(1'b0, OFF_STATUS, 32'h0); while (rd[2:0] === 3'b000);
    chk(rd & 32'h7, st);
    chk({26'h0, pkt[45:40]}, {26'h0, idx});
    chk(pkt[39:8], arg);
    chk({31'h0, crc_ok}, 32'h1);
    chk({31'h0, irq}, {31'h0, |(st[2:0] & ien)});
    wr(OFF_STATUS, 32'h7);
    rdc(OFF_STATUS, 32'h0);
  endtask
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    htrans = 2'b00;
    haddr = 32'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    mode = 2'd0;
    bad = 1'b0;
    busy = 1'b0;
    fresh();
    wr(8'h30, 32'hffff_ffff);
    rdc(8'h30, 32'h0);
    for (int d = 1; d < 4; d++) begin
      wr(OFF_CLK_CTRL, 32'(d));
      rises(12 * (d + 1), 12);
    end
    wr(OFF_IRQ_EN, 32'h7);
    ien = 3'h7;
    cmd(6'h00, 32'h1234_5678, 2'b00, 32'h1);
    mode <= 2'd1;
    cmd(6'h08, 32'hc0de_0001, 2'b01, 32'h1);
    rdc(OFF_RESP_IDX, 32'h8);
    rdc(OFF_RESP_ARG0, ~32'hc0de_0001);
    bad <= 1'b1;
    cmd(6'h0b, 32'h5555_aaaa, 2'b01, 32'h3);
    bad <= 1'b0;
    mode <= 2'd2;
    cmd(6'h02, 32'h8765_4321, 2'b11, 32'h1);
    for (int i = 0; i < 4; i++)
      rdc(OFF_RESP_ARG0 + 8'(4 * i), 32'h8765_4321);
    busy <= 1'b1;
    repeat (4) @(posedge hclk);
    rdc(OFF_DAT_STAT, 32'h01);
    busy <= 1'b0;
    wr(OFF_CLK_CTRL, 32'h203);
    repeat (4) @(posedge hclk);
    rdc(OFF_DAT_STAT, 32'hf0);
    mode <= 2'd0;
    wr(OFF_IRQ_EN, 32'h3);
    ien = 3'h3;
    cmd(6'h05, 32'h0, 2'b01, 32'h4);
    fresh();
    mode <= 2'd1;
    cmd(6'h0d, 32'h0000_ff00, 2'b01, 32'h1);
    close_out();
  end
  initial begin
    repeat (40000) @(posedge hclk);
    bad_count++;
    close_out();
  end
endmodule
